// ---- core/crt_raster_timing_controller.sv ----
// Raster timing generator with indexed byte-wide register file.
// Assumes all inputs are synchronous to the character clock clk.
`default_nettype none

module crt_raster_timing_controller (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_clear_n,
  input wire logic cs_n,
  input wire logic reg_space_select,
  input wire logic rw,
  input wire logic e,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic pen_strobe_in,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic active_video_window,
  output logic cursor_video_out,
  output logic [13:0] refresh_addr_out,
  output logic [4:0] glyph_line_index
);

  // ---------------------------------------------------------------
  // Programmed registers
  // ---------------------------------------------------------------
  logic [4:0] register_index;
  logic [7:0] line_length_total;
  logic [7:0] visible_chars_per_row;
  logic [7:0] line_sync_start;
  logic [3:0] line_sync_width;
  logic [6:0] frame_rows_total;
  logic [4:0] frame_extra_scanlines;
  logic [6:0] visible_rows;
  logic [6:0] frame_sync_start_row;
  logic [1:0] scan_interlace_select;
  logic [4:0] scanlines_per_row;
  logic [6:0] cursor_top_line;
  logic [4:0] cursor_bottom_line;
  logic [5:0] page_origin_high;
  logic [7:0] page_origin_low;
  logic [5:0] cursor_location_high;
  logic [7:0] cursor_location_low;
  logic [5:0] pen_hit_high;
  logic [7:0] pen_hit_low;

  logic e_q;
  logic pen_q;
  logic wr_stb;
  logic rd_act;
  logic [7:0] rd_value;
  logic clear_act;

  assign wr_stb = !cs_n && !rw && e && !e_q;
  assign rd_act = !cs_n && rw && e;
  assign clear_act = !chip_clear_n && !pen_strobe_in;

  // ---------------------------------------------------------------
  // Host writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      e_q <= 1'b0;
    end else begin
      e_q <= e;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      register_index <= 5'h00;
      line_length_total <= 8'h00;
      visible_chars_per_row <= 8'h00;
      line_sync_start <= 8'h00;
      line_sync_width <= 4'h0;
      frame_rows_total <= 7'h00;
      frame_extra_scanlines <= 5'h00;
      visible_rows <= 7'h00;
      frame_sync_start_row <= 7'h00;
      scan_interlace_select <= 2'h0;
      scanlines_per_row <= 5'h00;
      cursor_top_line <= 7'h00;
      cursor_bottom_line <= 5'h00;
      page_origin_high <= 6'h00;
      page_origin_low <= 8'h00;
      cursor_location_high <= 6'h00;
      cursor_location_low <= 8'h00;
    end else if (wr_stb) begin
      if (!reg_space_select) begin
        register_index <= data_in[4:0];
      end else begin
        case (register_index)
          crt_pkg::IDX_LINE_TOTAL: line_length_total <= data_in;
          crt_pkg::IDX_VISIBLE_CHARS: visible_chars_per_row <= data_in;
          crt_pkg::IDX_LINE_SYNC_START: line_sync_start <= data_in;
          crt_pkg::IDX_LINE_SYNC_WIDTH: line_sync_width <= data_in[3:0];
          crt_pkg::IDX_FRAME_ROWS: frame_rows_total <= data_in[6:0];
          crt_pkg::IDX_FRAME_EXTRA: frame_extra_scanlines <= data_in[4:0];
          crt_pkg::IDX_VISIBLE_ROWS: visible_rows <= data_in[6:0];
          crt_pkg::IDX_FRAME_SYNC_ROW: frame_sync_start_row <= data_in[6:0];
          crt_pkg::IDX_SCAN_MODE: scan_interlace_select <= data_in[1:0];
          crt_pkg::IDX_SCANLINES: scanlines_per_row <= data_in[4:0];
          crt_pkg::IDX_CURSOR_TOP: cursor_top_line <= data_in[6:0];
          crt_pkg::IDX_CURSOR_BOTTOM: cursor_bottom_line <= data_in[4:0];
          crt_pkg::IDX_ORIGIN_HIGH: page_origin_high <= data_in[5:0];
          crt_pkg::IDX_ORIGIN_LOW: page_origin_low <= data_in;
          crt_pkg::IDX_CURSOR_HIGH: cursor_location_high <= data_in[5:0];
          crt_pkg::IDX_CURSOR_LOW: cursor_location_low <= data_in;
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Host reads
  // ---------------------------------------------------------------
  always_comb begin
    rd_value = 8'h00;
    if (reg_space_select) begin
      case (register_index)
        crt_pkg::IDX_CURSOR_HIGH: rd_value = {2'h0, cursor_location_high};
        crt_pkg::IDX_CURSOR_LOW: rd_value = cursor_location_low;
        crt_pkg::IDX_PEN_HIGH: rd_value = {2'h0, pen_hit_high};
        crt_pkg::IDX_PEN_LOW: rd_value = pen_hit_low;
        default: rd_value = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_out <= rd_act ? rd_value : 8'h00;
      data_oe_n <= !rd_act;
    end
  end

  // ---------------------------------------------------------------
  // Raster counters
  // ---------------------------------------------------------------
  logic [7:0] hcnt;
  logic [6:0] row;
  logic [4:0] adj_cnt;
  logic in_adjust;
  logic field;
  logic [4:0] field_cnt;
  logic [13:0] row_start;
  logic [4:0] vs_left;
  logic [3:0] hs_left;
  logic line_end;
  logic video_mode;
  logic row_last;
  logic [13:0] origin;
  logic [13:0] next_row_start_addr;
  logic [13:0] next_line_addr;
  logic [4:0] next_ra;
  logic [6:0] next_row;
  logic next_in_adjust;
  logic [4:0] next_adj_cnt;
  logic next_frame;
  logic row_begins;

  assign origin = {page_origin_high, page_origin_low};
  assign line_end = (hcnt == line_length_total);
  assign video_mode = (scan_interlace_select == crt_pkg::MODE_INTERLACE_VIDEO);
  assign next_row_start_addr = row_start + {6'h00, visible_chars_per_row};

  always_comb begin
    row_last = 1'b0;
    if (video_mode) begin
      row_last = ({1'b0, glyph_line_index} + 6'h02) > {1'b0, scanlines_per_row};
    end else begin
      row_last = (glyph_line_index == scanlines_per_row);
    end
  end

  always_comb begin
    next_ra = glyph_line_index;
    next_row = row;
    next_in_adjust = in_adjust;
    next_adj_cnt = adj_cnt;
    next_line_addr = row_start;
    next_frame = 1'b0;
    row_begins = 1'b0;
    if (in_adjust) begin
      if ((adj_cnt + 5'h01) == frame_extra_scanlines) begin
        next_frame = 1'b1;
      end else begin
        next_adj_cnt = adj_cnt + 5'h01;
        next_ra = glyph_line_index + 5'h01;
      end
    end else if (row_last) begin
      if (row == frame_rows_total) begin
        if (frame_extra_scanlines == 5'h00) begin
          next_frame = 1'b1;
        end else begin
          next_in_adjust = 1'b1;
          next_adj_cnt = 5'h00;
          next_ra = 5'h00;
          next_line_addr = next_row_start_addr;
        end
      end else begin
        next_row = row + 7'h01;
        next_ra = (video_mode && field) ? 5'h01 : 5'h00;
        next_line_addr = next_row_start_addr;
        row_begins = 1'b1;
      end
    end else begin
      next_ra = glyph_line_index + (video_mode ? 5'h02 : 5'h01);
    end
    if (next_frame) begin
      next_row = 7'h00;
      next_in_adjust = 1'b0;
      next_adj_cnt = 5'h00;
      next_ra = (video_mode && !field) ? 5'h01 : 5'h00;
      next_line_addr = origin;
      row_begins = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hcnt <= 8'h00;
      refresh_addr_out <= 14'h0000;
    end else if (clear_act) begin
      hcnt <= 8'h00;
      refresh_addr_out <= 14'h0000;
    end else if (line_end) begin
      hcnt <= 8'h00;
      refresh_addr_out <= next_line_addr;
    end else begin
      hcnt <= hcnt + 8'h01;
      refresh_addr_out <= refresh_addr_out + 14'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      row <= 7'h00;
      glyph_line_index <= 5'h00;
      in_adjust <= 1'b0;
      adj_cnt <= 5'h00;
      field <= 1'b0;
      field_cnt <= 5'h00;
      row_start <= 14'h0000;
    end else if (clear_act) begin
      row <= 7'h00;
      glyph_line_index <= 5'h00;
      in_adjust <= 1'b0;
      adj_cnt <= 5'h00;
      field <= 1'b0;
      field_cnt <= 5'h00;
      row_start <= origin;
    end else if (line_end) begin
      row <= next_row;
      glyph_line_index <= next_ra;
      in_adjust <= next_in_adjust;
      adj_cnt <= next_adj_cnt;
      row_start <= next_line_addr;
      if (next_frame) begin
        field <= !field;
        field_cnt <= field_cnt + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sync pulse timers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_left <= 4'h0;
    end else if (clear_act) begin
      hs_left <= 4'h0;
    end else if (hcnt == line_sync_start) begin
      hs_left <= line_sync_width;
    end else if (hs_left != 4'h0) begin
      hs_left <= hs_left - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vs_left <= 5'h00;
    end else if (clear_act) begin
      vs_left <= 5'h00;
    end else if (line_end) begin
      if (row_begins && next_row == frame_sync_start_row) begin
        vs_left <= crt_pkg::FRAME_SYNC_LINES;
      end else if (vs_left != 5'h00) begin
        vs_left <= vs_left - 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Window, cursor and output strobes
  // ---------------------------------------------------------------
  crt_pkg::crt_video_t vid_now;
  logic blink_on;
  logic line_in_cursor;

  always_comb begin
    blink_on = 1'b1;
    case (cursor_top_line[6:5])
      crt_pkg::CURSOR_STEADY: blink_on = 1'b1;
      crt_pkg::CURSOR_HIDDEN: blink_on = 1'b0;
      crt_pkg::CURSOR_BLINK16: blink_on = field_cnt[crt_pkg::BLINK16_BIT];
      crt_pkg::CURSOR_BLINK32: blink_on = field_cnt[crt_pkg::BLINK32_BIT];
      default: blink_on = 1'b1;
    endcase
  end

  assign line_in_cursor = (glyph_line_index >= cursor_top_line[4:0]) &&
                          (glyph_line_index <= cursor_bottom_line);

  always_comb begin
    vid_now.line_sync = (hs_left != 4'h0);
    vid_now.frame_sync = (vs_left != 5'h00);
    vid_now.window = (hcnt < visible_chars_per_row) && !in_adjust &&
                     (row < visible_rows);
    vid_now.cursor = vid_now.window && blink_on && line_in_cursor &&
                     (refresh_addr_out == {cursor_location_high, cursor_location_low});
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_sync_out <= 1'b0;
      frame_sync_out <= 1'b0;
      active_video_window <= 1'b0;
      cursor_video_out <= 1'b0;
    end else if (clear_act) begin
      line_sync_out <= 1'b0;
      frame_sync_out <= 1'b0;
      active_video_window <= 1'b0;
      cursor_video_out <= 1'b0;
    end else begin
      line_sync_out <= vid_now.line_sync;
      frame_sync_out <= vid_now.frame_sync;
      active_video_window <= vid_now.window;
      cursor_video_out <= vid_now.cursor;
    end
  end

  // ---------------------------------------------------------------
  // Pen capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pen_q <= 1'b0;
      pen_hit_high <= 6'h00;
      pen_hit_low <= 8'h00;
    end else begin
      pen_q <= pen_strobe_in;
      if (pen_strobe_in && !pen_q) begin
        pen_hit_high <= refresh_addr_out[13:8];
        pen_hit_low <= refresh_addr_out[7:0];
      end
    end
  end

endmodule // crt_raster_timing_controller

`default_nettype wire

// ---- core/crt_pkg.sv ----
// Constants and carrier types for the raster timing controller.
// Assumes a single character clock domain and a byte-wide host bus.
// How it works
// - Data bus driven only during host reads
// - Chip select, strobe, space select qualify access
// - Frame starts at page origin, reloaded live
// - Clear zeroes counters and outputs, keeps registers
// - Clear acts only while pen strobe low
// - Clear held one clock zeroes address outputs
// - Display restarts at once after clear
// - Line sync width 1-15, zero suppresses
// - Frame sync lasts sixteen scan lines
// - Video window only inside both display periods
// - Cursor video forced off outside window
// - Pen strobe latches current refresh address
// - Index 18 to 31 selects nothing
// - Line total minus one; visible below total
// - Sync start minus one; sync fits line
// - Frame rows total minus one
// - Extra scan lines appended each frame
// - Sync row within total; visible rows below
// - Scan mode: interlace video at 3, plain otherwise
// - Scanlines per row minus one
// - Cursor top holds start line and blink mode
// - Cursor pair read-write, pen pair read-only
// - Interlace video: even lines even field
`default_nettype none

package crt_pkg;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_LINE_TOTAL = 5'h00;
  localparam logic [4:0] IDX_VISIBLE_CHARS = 5'h01;
  localparam logic [4:0] IDX_LINE_SYNC_START = 5'h02;
  localparam logic [4:0] IDX_LINE_SYNC_WIDTH = 5'h03;
  localparam logic [4:0] IDX_FRAME_ROWS = 5'h04;
  localparam logic [4:0] IDX_FRAME_EXTRA = 5'h05;
  localparam logic [4:0] IDX_VISIBLE_ROWS = 5'h06;
  localparam logic [4:0] IDX_FRAME_SYNC_ROW = 5'h07;
  localparam logic [4:0] IDX_SCAN_MODE = 5'h08;
  localparam logic [4:0] IDX_SCANLINES = 5'h09;
  localparam logic [4:0] IDX_CURSOR_TOP = 5'h0a;
  localparam logic [4:0] IDX_CURSOR_BOTTOM = 5'h0b;
  localparam logic [4:0] IDX_ORIGIN_HIGH = 5'h0c;
  localparam logic [4:0] IDX_ORIGIN_LOW = 5'h0d;
  localparam logic [4:0] IDX_CURSOR_HIGH = 5'h0e;
  localparam logic [4:0] IDX_CURSOR_LOW = 5'h0f;
  localparam logic [4:0] IDX_PEN_HIGH = 5'h10;
  localparam logic [4:0] IDX_PEN_LOW = 5'h11;

  // ---------------------------------------------------------------
  // Field values and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] CURSOR_STEADY = 2'h0;
  localparam logic [1:0] CURSOR_HIDDEN = 2'h1;
  localparam logic [1:0] CURSOR_BLINK16 = 2'h2;
  localparam logic [1:0] CURSOR_BLINK32 = 2'h3;
  localparam logic [1:0] MODE_INTERLACE_VIDEO = 2'h3;
  localparam logic [4:0] FRAME_SYNC_LINES = 5'h10;
  localparam int BLINK16_BIT = 3;
  localparam int BLINK32_BIT = 4;

  // ---------------------------------------------------------------
  // Carrier for the display-side strobes
  // ---------------------------------------------------------------
  typedef struct packed {
    logic line_sync;
    logic frame_sync;
    logic window;
    logic cursor;
  } crt_video_t;

endpackage : crt_pkg

`default_nettype wire

// ---- bench/crt_raster_props.sv ----
// Port checker for the raster timing controller.
// Assumes it is bound to the controller top module.
`default_nettype none

module crt_raster_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_clear_n,
  input wire logic cs_n,
  input wire logic reg_space_select,
  input wire logic rw,
  input wire logic e,
  input wire logic [7:0] data_in,
  input wire logic data_oe_n,
  input wire logic pen_strobe_in,
  input wire logic line_sync_out,
  input wire logic frame_sync_out,
  input wire logic active_video_window,
  input wire logic cursor_video_out,
  input wire logic [13:0] refresh_addr_out,
  input wire logic [4:0] glyph_line_index
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] sh_idx;
  logic [3:0] sh_w;
  logic [7:0] sh_tot;
  logic e_q;
  logic [3:0] hs_len;
  logic [12:0] vs_len;
  logic rd_req;
  assign rd_req = !cs_n && rw && e;
  // ----------------------------------------
  // Shadow of host writes
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      e_q <= 1'b0;
      sh_idx <= 5'h00;
      sh_w <= 4'h0;
      sh_tot <= 8'h00;
    end else begin
      e_q <= e;
      if (!cs_n && !rw && e && !e_q) begin
        if (!reg_space_select) begin
          sh_idx <= data_in[4:0];
        end else if (sh_idx == crt_pkg::IDX_LINE_SYNC_WIDTH) begin
          sh_w <= data_in[3:0];
        end else if (sh_idx == crt_pkg::IDX_LINE_TOTAL) begin
          sh_tot <= data_in;
        end
      end
    end
  end
  // Pulse lengths in clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_len <= 4'h0;
      vs_len <= 13'h0000;
    end else begin
      hs_len <= line_sync_out ? hs_len + 4'h1 : 4'h0;
      vs_len <= frame_sync_out ? vs_len + 13'h0001 : 13'h0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_drives_bus: assert property (rd_req |=> !data_oe_n)
    else $error("bus not driven on read");
  a_bus_idle_hiz: assert property (!data_oe_n |->
    ($past(rd_req) || $past(rd_req, 2)))
    else $error("bus driven outside read");
  a_clear_zeroes_outputs: assert property ((!chip_clear_n && !pen_strobe_in) |=>
    refresh_addr_out == 14'h0000 && glyph_line_index == 5'h00 && !line_sync_out &&
    !frame_sync_out && !active_video_window && !cursor_video_out)
    else $error("outputs not cleared");
  a_restart_at_once: assert property (($rose(chip_clear_n) && !$past(pen_strobe_in)) |=>
    refresh_addr_out == 14'h0001)
    else $error("no restart after clear");
  a_cursor_in_window: assert property (cursor_video_out |-> active_video_window)
    else $error("cursor outside window");
  a_hsync_width: assert property (($fell(line_sync_out) && $past(chip_clear_n)) |->
    hs_len == sh_w)
    else $error("line sync width wrong");
  a_hsync_zero_off: assert property (sh_w == 4'h0 |-> !line_sync_out)
    else $error("line sync with zero width");
  a_vsync_sixteen_lines: assert property (($fell(frame_sync_out) && $past(chip_clear_n)) |->
    vs_len == ({5'h00, sh_tot} + 13'h0001) * 13'h0010)
    else $error("frame sync length wrong");
  c_line_sync: cover property ($fell(line_sync_out));
  c_frame_sync: cover property ($fell(frame_sync_out));
  c_cursor: cover property ($rose(cursor_video_out));
endmodule // crt_raster_props

bind crt_raster_timing_controller crt_raster_props i_props (.clk(clk), .sys_rst(sys_rst),
  .chip_clear_n(chip_clear_n), .cs_n(cs_n), .reg_space_select(reg_space_select), .rw(rw),
  .e(e), .data_in(data_in), .data_oe_n(data_oe_n), .pen_strobe_in(pen_strobe_in),
  .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
  .active_video_window(active_video_window), .cursor_video_out(cursor_video_out),
  .refresh_addr_out(refresh_addr_out), .glyph_line_index(glyph_line_index));

`default_nettype wire

// ---- bench/crt_pen_model.sv ----
// Light pen and video mixer on the display side.
// Assumes the bench commands each pen hit through fire.
`default_nettype none

module crt_pen_model (
  input wire logic fire,
  input wire logic active_video_window,
  input wire logic cursor_video_out,
  output logic pen_strobe_in,
  output logic video
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pen pulse follows the bench command
  assign pen_strobe_in = fire;
  // Video passes only inside the window
  assign video = active_video_window & cursor_video_out;
endmodule // crt_pen_model

`default_nettype wire

// ---- bench/crt_raster_timing_controller_tb_top.sv ----
// Self-checking bench for the raster timing controller.
// Assumes the core package, the design, the pen model and the checker.
`default_nettype none

module crt_raster_timing_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, chip_clear_n, cs_n, reg_space_select, rw, e, fire, oe_q;
  logic data_oe_n, pen_strobe_in, line_sync_out, frame_sync_out, video, hit;
  logic active_video_window, cursor_video_out;
  logic [7:0] data_in, data_out;
  logic [13:0] refresh_addr_out;
  logic [4:0] glyph_line_index;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  // Legal timing set
  logic [12:0] prog [14] = '{13'h0007, 13'h0104, 13'h0205, 13'h0302, 13'h0403, 13'h0502,
    13'h0602, 13'h0702, 13'h0903, 13'h0a01, 13'h0b02, 13'h0d10, 13'h0e00, 13'h0f16};
  int fail_count, check_count, n, p;

  crt_raster_timing_controller i_dut (.clk(clk), .sys_rst(sys_rst),
    .chip_clear_n(chip_clear_n), .cs_n(cs_n), .reg_space_select(reg_space_select),
    .rw(rw), .e(e), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .pen_strobe_in(pen_strobe_in), .line_sync_out(line_sync_out),
    .frame_sync_out(frame_sync_out), .active_video_window(active_video_window),
    .cursor_video_out(cursor_video_out), .refresh_addr_out(refresh_addr_out),
    .glyph_line_index(glyph_line_index));
  crt_pen_model i_pen (.fire(fire), .active_video_window(active_video_window),
    .cursor_video_out(cursor_video_out), .pen_strobe_in(pen_strobe_in), .video(video));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One host cycle: one clock with strobe high, then one low
  task automatic bus(input logic rs, input logic rd_n, input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    reg_space_select = rs;
    rw = rd_n;
    e = 1'b1;
    data_in = d;
    @(negedge clk);
    cs_n = 1'b1;
    e = 1'b0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    bus(1'b0, 1'b0, {3'h0, idx});
    bus(1'b1, 1'b0, d);
  endtask

  task automatic rd(input logic [4:0] idx, input logic [7:0] want);
    bus(1'b0, 1'b0, {3'h0, idx});
    exp_q.push_back(want);
    bus(1'b1, 1'b1, 8'h00);
  endtask

  // Waits for the next frame sync rise, noting any cursor
  task automatic frame(output logic seen);
    logic prev;
    int t;
    seen = 1'b0;
    prev = frame_sync_out;
    t = 0;
    while (!(frame_sync_out === 1'b1 && prev === 1'b0)) begin
      prev = frame_sync_out;
      @(negedge clk);
      seen = seen | cursor_video_out;
      t++;
      if (t > 400) begin
        fail_count++;
        $display("ERROR t=%0t frame timeout", $time);
        tally_and_finish();
      end
    end
  endtask

  // Oldest note is compared when a read result appears
  always @(negedge clk) begin
    if (data_oe_n === 1'b0 && oe_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        check({8'h00, data_out}, {8'h00, exp_q.pop_front()});
      end
    end
    oe_q = data_oe_n;
  end

  initial begin
    sys_rst = 1'b1;
    chip_clear_n = 1'b0;
    cs_n = 1'b1;
    reg_space_select = 1'b0;
    rw = 1'b1;
    e = 1'b0;
    data_in = 8'h00;
    fire = 1'b0;
    seed = 32'd86;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    rd(crt_pkg::IDX_CURSOR_LOW, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = rnd();
      wr(crt_pkg::IDX_CURSOR_HIGH, seed[7:0]);
      wr(crt_pkg::IDX_CURSOR_LOW, seed[15:8]);
      rd(crt_pkg::IDX_CURSOR_HIGH, seed[7:0] & 8'h3f);
      rd(crt_pkg::IDX_CURSOR_LOW, seed[15:8]);
    end
    for (int i = 18; i < 32; i++) begin
      wr(5'(i), 8'hff);
    end
    rd(crt_pkg::IDX_CURSOR_LOW, seed[15:8]);
    foreach (prog[i]) begin
      wr(prog[i][12:8], prog[i][7:0]);
    end
    // Second frame is compared position by position
    chip_clear_n = 1'b1;
    for (int m = 1; m < 272; m++) begin
      @(negedge clk);
      p = m - 144;
      fire = (m == 184);
      chip_clear_n = (m != 184);
      if (p >= 0 && p < 128) begin
        check(16'(refresh_addr_out), 16'(16 + (p / 32) * 4 + p % 8));
        check(16'(glyph_line_index), 16'((p / 8) % 4));
        check(16'(active_video_window), 16'(p < 64 && p % 8 >= 1 && p % 8 <= 4));
        check(16'(cursor_video_out), 16'(p >= 40 && p < 56 && p % 8 == 3));
        check(16'(video), 16'(p >= 40 && p < 56 && p % 8 == 3));
      end
    end
    wr(crt_pkg::IDX_PEN_LOW, 8'h77);
    rd(crt_pkg::IDX_PEN_LOW, 8'h14);
    rd(crt_pkg::IDX_PEN_HIGH, 8'h00);
    rd(crt_pkg::IDX_LINE_TOTAL, 8'h00);
    // Every cursor mode over 64 frames
    for (int k = 0; k < 4; k++) begin
      wr(crt_pkg::IDX_CURSOR_TOP, {1'b0, 2'(k), 5'h01});
      frame(hit);
      n = 0;
      repeat (64) begin
        frame(hit);
        n = n + int'(hit);
      end
      check(16'(n), (k == 0) ? 16'h0040 : (k == 1) ? 16'h0000 : 16'h0020);
    end
    chip_clear_n = 1'b0;
    wr(crt_pkg::IDX_LINE_SYNC_WIDTH, 8'h00);
    chip_clear_n = 1'b1;
    hit = 1'b0;
    repeat (300) begin
      @(negedge clk);
      hit = hit | line_sync_out;
    end
    check(16'(hit), 16'h0000);
    // Interlaced video: each field shows one line parity
    chip_clear_n = 1'b0;
    wr(crt_pkg::IDX_CURSOR_BOTTOM, 8'h03);
    wr(crt_pkg::IDX_SCAN_MODE, 8'h03);
    chip_clear_n = 1'b1;
    repeat (200) @(negedge clk);
    n = 0;
    p = 0;
    repeat (160) begin
      @(negedge clk);
      if (active_video_window === 1'b1) begin
        n = n + int'(glyph_line_index[0]);
        p = p + int'(!glyph_line_index[0]);
      end
    end
    check(16'(n), 16'h0010);
    check(16'(p), 16'h0010);
    check(16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule // crt_raster_timing_controller_tb_top

`default_nettype wire
